// ---- design/blhc_ctrl.sv ----
`timescale 1ns/100ps
`include "blhc_defs.svh"
// Function
// R1: locked operations lock at least the destination bytes; whole bus locked here.
// R2: lock prefix accepted at any privilege level, no protection fault.
// R3: on interrupt request, assert bus lock until the vector is received.
// R4: interrupt controller delivers the vector on the data bus while locked.
// R5: hold may be granted between pieces of an unaligned operand.
// R6: hold requests are answered during reset initialization too.
// R7: all buffered memory writes drain before a locked cycle starts.
// R8: lock stays on across a whole locked sequence; no hold until released.
module blhc_ctrl
    import blhc_pkg::*;
#(
    parameter int INIT_CYCLES = `BLHC_INIT_CYCLES,
    parameter int WBUF_DEPTH_W = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // core request side
    input wire logic req_valid_i,
    input wire logic req_locked_i,
    input wire logic req_last_i,
    input wire logic req_write_i,
    input wire logic req_buffered_i,
    input wire logic [`BLHC_ADDR_W-1:0] req_addr_i,
    input wire logic [`BLHC_DATA_W-1:0] req_wdata_i,
    input wire logic [`BLHC_PRIV_W-1:0] current_privilege_level_i,
    input wire logic [`BLHC_PRIV_W-1:0] io_privilege_level_i,
    output logic req_ready_o,
    output logic prot_fault_o,
    output logic wbuf_full_o,
    output logic init_done_o,
    // external bus
    input wire logic bus_done_pin_i,
    input wire logic hold_req_pin_i,
    input wire logic intr_pin_i,
    input wire logic [`BLHC_DATA_W-1:0] bus_data_pin_i,
    output logic bus_start_o,
    output logic bus_write_o,
    output logic bus_inta_o,
    output logic [`BLHC_ADDR_W-1:0] bus_addr_o,
    output logic [`BLHC_DATA_W-1:0] bus_data_o,
    output logic bus_data_oe_o,
    output logic bus_lock_n_o,
    output logic hold_ack_o,
    output logic [`BLHC_VEC_W-1:0] intr_vector_o,
    output logic intr_vector_valid_o
);
    typedef enum logic [2:0] {
        BLHC_IDLE,
        BLHC_DRAIN,
        BLHC_XFER,
        BLHC_INTA,
        BLHC_HOLD
    } blhc_state_t;

    blhc_state_t state_ff;
    logic [1:0] done_sync_ff;
    logic [1:0] hold_sync_ff;
    logic [1:0] intr_sync_ff;
    logic [`BLHC_DATA_W-1:0] data_s1_ff;
    logic [`BLHC_DATA_W-1:0] data_s2_ff;
    logic [15:0] init_cnt_ff;
    logic lock_seq_ff;
    logic cur_locked_ff;
    logic cur_buf_ff;
    blhc_op_t op_ff;
    logic wbuf_empty;
    logic wbuf_full;
    logic done_s;
    logic hold_s;
    logic intr_s;
    logic take_req;
    logic retire_buf;

    assign done_s = done_sync_ff[1];
    assign hold_s = hold_sync_ff[1];
    assign intr_s = intr_sync_ff[1];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_sync_ff <= 2'h0;
            hold_sync_ff <= 2'h0;
            intr_sync_ff <= 2'h0;
            data_s1_ff <= '0;
            data_s2_ff <= '0;
        end else begin
            done_sync_ff <= {done_sync_ff[0], bus_done_pin_i};
            hold_sync_ff <= {hold_sync_ff[0], hold_req_pin_i};
            intr_sync_ff <= {intr_sync_ff[0], intr_pin_i};
            data_s1_ff <= bus_data_pin_i;
            data_s2_ff <= data_s1_ff;
        end
    end

    // reset initialization timer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            init_cnt_ff <= 16'h0000;
        end else if (init_cnt_ff != INIT_CYCLES[15:0]) begin
            init_cnt_ff <= init_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            init_done_o <= 1'b0;
        end else begin
            init_done_o <= (init_cnt_ff == INIT_CYCLES[15:0]);
        end
    end

    // no privilege check on the lock prefix
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prot_fault_o <= 1'b0;
        end else begin
            prot_fault_o <= 1'b0; // R2
        end
    end

    // ready still high means the caller has not yet dropped the finished request
    // inside a locked sequence hold and interrupt wait for the last piece
    assign take_req = (state_ff == BLHC_IDLE) && init_done_o && req_valid_i && !req_ready_o
        && (lock_seq_ff || (!hold_s && !intr_s)); // R8
    assign retire_buf = (state_ff == BLHC_XFER) && done_s && cur_buf_ff;

    blhc_drain #(
        .DEPTH_W(WBUF_DEPTH_W)
    ) u_drain (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .push_i(take_req && req_write_i && req_buffered_i && !req_locked_i),
        .pop_i(retire_buf),
        .empty_o(wbuf_empty),
        .full_o(wbuf_full)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wbuf_full_o <= 1'b0;
        end else begin
            wbuf_full_o <= wbuf_full;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= BLHC_IDLE;
            lock_seq_ff <= 1'b0;
            cur_locked_ff <= 1'b0;
            cur_buf_ff <= 1'b0;
            op_ff <= BLHC_OP_READ;
            bus_addr_o <= '0;
            bus_data_o <= '0;
        end else begin
            case (state_ff)
                BLHC_IDLE: begin
                    if (hold_s && !lock_seq_ff) begin
                        state_ff <= BLHC_HOLD; // R5 R6 R8
                    end else if (init_done_o && intr_s && !lock_seq_ff) begin
                        op_ff <= BLHC_OP_INTA;
                        state_ff <= BLHC_INTA; // R3
                    end else if (take_req) begin
                        cur_locked_ff <= req_locked_i; // R1
                        cur_buf_ff <= req_write_i && req_buffered_i && !req_locked_i;
                        op_ff <= req_write_i ? BLHC_OP_WRITE : BLHC_OP_READ;
                        bus_addr_o <= req_addr_i;
                        bus_data_o <= req_wdata_i;
                        state_ff <= (req_locked_i && !lock_seq_ff) ? BLHC_DRAIN : BLHC_XFER;
                        if (req_locked_i) begin
                            lock_seq_ff <= !req_last_i; // R8
                        end
                    end
                end
                BLHC_DRAIN: begin
                    if (wbuf_empty) begin
                        state_ff <= BLHC_XFER; // R7
                    end
                end
                BLHC_XFER: begin
                    if (done_s) begin
                        state_ff <= BLHC_IDLE;
                    end
                end
                BLHC_INTA: begin
                    if (done_s) begin
                        state_ff <= BLHC_IDLE; // R4
                    end
                end
                BLHC_HOLD: begin
                    if (!hold_s) begin
                        state_ff <= BLHC_IDLE;
                    end
                end
                default: begin
                    state_ff <= BLHC_IDLE;
                end
            endcase
        end
    end

    // bus strobes and lock pin
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_start_o <= 1'b0;
            bus_write_o <= 1'b0;
            bus_inta_o <= 1'b0;
            bus_data_oe_o <= 1'b0;
            bus_lock_n_o <= 1'b1;
            hold_ack_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            bus_start_o <= (state_ff == BLHC_IDLE && take_req && !(req_locked_i && !lock_seq_ff))
                || (state_ff == BLHC_DRAIN && wbuf_empty)
                || (state_ff == BLHC_IDLE && init_done_o && intr_s && !hold_s && !lock_seq_ff);
            bus_write_o <= (state_ff == BLHC_XFER) && (op_ff == BLHC_OP_WRITE);
            bus_inta_o <= (state_ff == BLHC_INTA);
            bus_data_oe_o <= (state_ff == BLHC_XFER) && (op_ff == BLHC_OP_WRITE);
            // lock falls together with the start of a lone locked cycle
            bus_lock_n_o <= !((state_ff == BLHC_INTA) || lock_seq_ff
                || ((state_ff == BLHC_DRAIN) && wbuf_empty)
                || ((state_ff == BLHC_XFER) && cur_locked_ff)); // R3 R8
            hold_ack_o <= (state_ff == BLHC_HOLD) && hold_s; // R6
            req_ready_o <= ((state_ff == BLHC_XFER) && done_s);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            intr_vector_o <= '0;
            intr_vector_valid_o <= 1'b0;
        end else begin
            intr_vector_valid_o <= (state_ff == BLHC_INTA) && done_s;
            if (state_ff == BLHC_INTA && done_s) begin
                intr_vector_o <= data_s2_ff[`BLHC_VEC_W-1:0];
            end
        end
    end
endmodule

// ---- common/blhc_defs.svh ----
`ifndef BLHC_DEFS_SVH
`define BLHC_DEFS_SVH

`define BLHC_PRIV_W 2
`define BLHC_ADDR_W 32
`define BLHC_DATA_W 32
`define BLHC_VEC_W 8
`define BLHC_INIT_CYCLES 16'h0040

`endif

// ---- common/blhc_pkg.sv ----
package blhc_pkg;
    typedef enum logic [1:0] {
        BLHC_OP_READ,
        BLHC_OP_WRITE,
        BLHC_OP_INTA
    } blhc_op_t;
endpackage

// ---- design/blhc_drain.sv ----
`timescale 1ns/100ps
`include "blhc_defs.svh"
// counts buffered memory writes still waiting for the external bus
module blhc_drain #(
    parameter int DEPTH_W = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    output logic empty_o,
    output logic full_o
);
    logic [DEPTH_W:0] cnt_ff;
    logic [DEPTH_W:0] nxt_cnt;
    localparam logic [DEPTH_W:0] MAX_CNT = {1'b1, {DEPTH_W{1'b0}}};

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push_i && !full_o && !(pop_i && cnt_ff != '0)) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop_i && cnt_ff != '0 && !push_i) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign empty_o = (cnt_ff == '0);
    assign full_o = (cnt_ff == MAX_CNT);
endmodule

// ---- tb/blhc_ctrl_properties.sv ----
`timescale 1ns/100ps
module blhc_ctrl_properties #(
    parameter int INIT_CYCLES = 4,
    parameter int WBUF_DEPTH_W = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire logic req_locked_i,
    input wire logic req_last_i,
    input wire logic req_write_i,
    input wire logic req_ready_o,
    input wire logic prot_fault_o,
    input wire logic init_done_o,
    input wire logic hold_req_pin_i,
    input wire logic bus_start_o,
    input wire logic bus_write_o,
    input wire logic bus_inta_o,
    input wire logic bus_lock_n_o,
    input wire logic hold_ack_o,
    input wire logic intr_vector_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_NO_FAULT: assert property (req_valid_i && req_locked_i |=> !prot_fault_o)
        else $error("fault on locked request");
    AST_INTA_LOCK: assert property (bus_inta_o |-> !bus_lock_n_o)
        else $error("acknowledge without lock");
    AST_VEC_LOCKED: assert property (intr_vector_valid_o |-> $past(!bus_lock_n_o))
        else $error("vector taken outside lock");
    AST_HOLD_INIT: assert property (!init_done_o && hold_req_pin_i |-> ##[1:6] hold_ack_o)
        else $error("hold ignored during init");
    AST_HOLD_NO_LOCK: assert property (hold_ack_o |-> bus_lock_n_o)
        else $error("hold granted while locked");
    AST_HOLD_NO_START: assert property (hold_ack_o |-> !bus_start_o)
        else $error("bus cycle during hold");
    AST_START_PULSE: assert property (bus_start_o |=> !bus_start_o)
        else $error("start longer than a cycle");
    AST_LOCK_HELD: assert property (req_ready_o && req_locked_i && !req_last_i |=> !bus_lock_n_o)
        else $error("lock dropped between pieces");
    AST_LOCK_START: assert property (bus_start_o && !bus_write_o && req_valid_i && req_locked_i && !req_write_i
        |-> !bus_lock_n_o)
        else $error("locked cycle without lock");
    cover property (hold_ack_o && !init_done_o);
    cover property (intr_vector_valid_o);
    cover property (req_ready_o && req_locked_i && req_last_i);
    cover property (bus_start_o && !bus_lock_n_o && !bus_inta_o);
endmodule

// ---- tb/blhc_bus_model.sv ----
`timescale 1ns/100ps
module blhc_bus_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic inta_i,
    input wire logic [7:0] wait_i,
    input wire logic [7:0] vec_i,
    output logic done_o,
    output logic [31:0] data_o
);
    int cnt = -1;
    int keep = 0;
    initial done_o = 1'b0;
    initial data_o = 32'h0;
    always @(posedge clk_i) begin
        done_o <= (cnt == 0);
        cnt <= start_i ? int'(wait_i) : (cnt >= 0 ? cnt - 1 : -1);
        keep <= inta_i ? 4 : (keep > 0 ? keep - 1 : 0);
        // vector while acknowledging and for four cycles after release, then a toggling pattern
        data_o <= (inta_i || keep > 0) ? {24'h0, vec_i} : ~data_o;
    end
endmodule

// ---- tb/blhc_ctrl_tb.sv ----
`timescale 1ns/100ps
module blhc_ctrl_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, hold_req_pin_i = 1'b1, intr_pin_i = 1'b0, bus_done_pin_i;
    logic req_valid_i = 1'b0, req_locked_i = 1'b0, req_last_i = 1'b0, req_write_i = 1'b0, req_buffered_i = 1'b0;
    logic [31:0] req_addr_i = 32'h0000_1000, req_wdata_i = 32'ha5a5_0f0f, bus_data_pin_i, bus_addr_o, bus_data_o;
    logic [1:0] current_privilege_level_i = 2'h3, io_privilege_level_i = 2'h0;
    logic [7:0] wait_w = 8'h02, intr_vector_o;
    logic req_ready_o, prot_fault_o, wbuf_full_o, init_done_o, bus_start_o, bus_write_o, bus_inta_o;
    logic bus_data_oe_o, bus_lock_n_o, hold_ack_o, intr_vector_valid_o;
    logic pend = 1'b0, drain_bad = 1'b0, ack_seen = 1'b0;
    int errors = 0, compares = 0;
    initial forever #2 clk_i = ~clk_i;
    blhc_ctrl #(.INIT_CYCLES(8)) u_blhc_ctrl (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i),
        .req_locked_i(req_locked_i),
        .req_last_i(req_last_i),
        .req_write_i(req_write_i),
        .req_buffered_i(req_buffered_i),
        .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i),
        .current_privilege_level_i(current_privilege_level_i),
        .io_privilege_level_i(io_privilege_level_i),
        .req_ready_o(req_ready_o),
        .prot_fault_o(prot_fault_o),
        .wbuf_full_o(wbuf_full_o),
        .init_done_o(init_done_o),
        .bus_done_pin_i(bus_done_pin_i),
        .hold_req_pin_i(hold_req_pin_i),
        .intr_pin_i(intr_pin_i),
        .bus_data_pin_i(bus_data_pin_i),
        .bus_start_o(bus_start_o),
        .bus_write_o(bus_write_o),
        .bus_inta_o(bus_inta_o),
        .bus_addr_o(bus_addr_o),
        .bus_data_o(bus_data_o),
        .bus_data_oe_o(bus_data_oe_o),
        .bus_lock_n_o(bus_lock_n_o),
        .hold_ack_o(hold_ack_o),
        .intr_vector_o(intr_vector_o),
        .intr_vector_valid_o(intr_vector_valid_o)
    );
    blhc_bus_model u_blhc_bus_model (.clk_i(clk_i), .start_i(bus_start_o), .inta_i(bus_inta_o),
        .wait_i(wait_w), .vec_i(8'h5a), .done_o(bus_done_pin_i), .data_o(bus_data_pin_i));
    always @(posedge clk_i) begin
        // a buffered write is in flight from its start until its done pulse
        pend <= (bus_start_o && req_valid_i && req_write_i && req_buffered_i && !req_locked_i) ? 1'b1
            : (bus_done_pin_i ? 1'b0 : pend);
        if (bus_start_o && !bus_lock_n_o && !bus_inta_o && pend) drain_bad <= 1'b1;
        if (hold_ack_o) ack_seen <= 1'b1;
    end
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return req_ready_o;
            1: return hold_ack_o;
            2: return bus_inta_o;
            3: return intr_vector_valid_o;
            default: return init_done_o;
        endcase
    endfunction
    task automatic wait_on(input int k, input logic v);
        int n;
        n = 0;
        while (sig(k) !== v) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 500) begin
                errors++;
                report_and_stop();
            end
        end
    endtask
    // f is locked, last, write, buffered
    task automatic do_req(input logic [3:0] f);
        @(posedge clk_i);
        {req_valid_i, req_locked_i, req_last_i, req_write_i, req_buffered_i} <= {1'b1, f};
        @(posedge clk_i);
        #1;
        wait_on(0, 1'b1);
        check(bus_write_o, f[1]);
        check(bus_data_oe_o, f[1]);
        check(bus_addr_o, req_addr_i);
        check(bus_data_o, req_wdata_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask
    task automatic hold_in_init();
        wait_on(1, 1'b1);
        check(init_done_o, 1'b0);
        @(posedge clk_i);
        hold_req_pin_i <= 1'b0;
        wait_on(1, 1'b0);
        wait_on(4, 1'b1);
    endtask
    task automatic locked_rmw();
        wait_w <= 8'h14;
        do_req(4'b0011);
        do_req(4'b1000);
        hold_req_pin_i <= 1'b1;
        ack_seen <= 1'b0;
        #1;
        check(bus_lock_n_o, 1'b0);
        do_req(4'b1110);
        #1;
        check(ack_seen, 1'b0);
        check(drain_bad, 1'b0);
        check(wbuf_full_o, 1'b0);
        check(prot_fault_o, 1'b0);
        wait_on(1, 1'b1);
        check(bus_lock_n_o, 1'b1);
        @(posedge clk_i);
        hold_req_pin_i <= 1'b0;
        wait_on(1, 1'b0);
    endtask
    task automatic split_hold();
        wait_w <= 8'h04;
        do_req(4'b0000);
        hold_req_pin_i <= 1'b1;
        wait_on(1, 1'b1);
        check(bus_lock_n_o, 1'b1);
        @(posedge clk_i);
        hold_req_pin_i <= 1'b0;
        wait_on(1, 1'b0);
        do_req(4'b0000);
        // lone locked read locks only its own cycle
        do_req(4'b1100);
        #1;
        check(bus_lock_n_o, 1'b1);
    endtask
    task automatic intr_ack();
        @(posedge clk_i);
        intr_pin_i <= 1'b1;
        wait_on(2, 1'b1);
        check(bus_lock_n_o, 1'b0);
        @(posedge clk_i);
        intr_pin_i <= 1'b0;
        wait_on(3, 1'b1);
        check(intr_vector_o, 8'h5a);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        hold_in_init();
        locked_rmw();
        split_hold();
        intr_ack();
        repeat (10) @(posedge clk_i);
        report_and_stop();
    end
endmodule
bind blhc_ctrl blhc_ctrl_properties #(.INIT_CYCLES(INIT_CYCLES), .WBUF_DEPTH_W(WBUF_DEPTH_W)) u_props (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i),
    .req_locked_i(req_locked_i),
    .req_last_i(req_last_i),
    .req_write_i(req_write_i),
    .req_ready_o(req_ready_o),
    .prot_fault_o(prot_fault_o),
    .init_done_o(init_done_o),
    .hold_req_pin_i(hold_req_pin_i),
    .bus_start_o(bus_start_o),
    .bus_write_o(bus_write_o),
    .bus_inta_o(bus_inta_o),
    .bus_lock_n_o(bus_lock_n_o),
    .hold_ack_o(hold_ack_o),
    .intr_vector_valid_o(intr_vector_valid_o)
);
